// ===== common/rtc_pkg.sv
// Shared constants and types for the calendar and alarm register block.
// Assumes an 8-bit register port driven by the device's serial control decoder.
package rtc_pkg;

    // Register offsets
    localparam logic [7:0] OFS_SECOND = 8'h00;
    localparam logic [7:0] OFS_MINUTE = 8'h01;
    localparam logic [7:0] OFS_HOUR = 8'h02;
    localparam logic [7:0] OFS_DAY = 8'h03;
    localparam logic [7:0] OFS_MONTH = 8'h04;
    localparam logic [7:0] OFS_YEAR = 8'h05;
    localparam logic [7:0] OFS_WEEKDAY = 8'h06;
    localparam logic [7:0] OFS_ALM_SECOND = 8'h08;
    localparam logic [7:0] OFS_ALM_MINUTE = 8'h09;
    localparam logic [7:0] OFS_ALM_HOUR = 8'h0A;
    localparam logic [7:0] OFS_CTRL = 8'h10;

    // Writable bit masks; other bits are reserved and read zero, except the hour afternoon flag (bit 7) in 12-hour mode
    localparam logic [7:0] MASK_SECOND = 8'h7F;
    localparam logic [7:0] MASK_MINUTE = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_DAY = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_CTRL = 8'h09;

    // Field positions
    localparam int AFTERNOON_BIT = 7;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MODE12_BIT = 3;

    // Reset values
    localparam logic [7:0] RST_SECOND = 8'h00;
    localparam logic [7:0] RST_MINUTE = 8'h00;
    localparam logic [7:0] RST_HOUR = 8'h00;
    localparam logic [7:0] RST_DAY = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_WEEKDAY = 8'h00;
    localparam logic [7:0] RST_ALARM = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // Counting limits in BCD
    localparam logic [7:0] MAX_SIXTY = 8'h59;
    localparam logic [7:0] MAX_HOUR24 = 8'h23;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;
    localparam logic [7:0] MAX_WEEKDAY = 8'h06;
    localparam logic [7:0] MIN_ZERO = 8'h00;
    localparam logic [7:0] MIN_ONE = 8'h01;

    // Timing: one second from the system clock
    localparam longint CLK_HZ = 25000000;
    localparam longint SECOND_MS = 1000;
    localparam longint CYC_PER_SECOND = (SECOND_MS * CLK_HZ) / 1000;

    typedef struct packed {
        logic [7:0] second;
        logic [7:0] minute;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] weekday;
    } rtc_time_t;

    typedef struct packed {
        logic [7:0] second;
        logic [7:0] minute;
        logic [7:0] hour;
    } rtc_alarm_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wr_data;
    } rtc_req_t;

endpackage

// ===== dv/rtc_host_model.sv
// Host model: issues single-cycle register strobes as the serial decoder would.
// Assumes the block answers a read one cycle after the strobe.
`timescale 1ns/100ps
module rtc_host_model (
    input wire logic clk_sys,
    output rtc_pkg::rtc_req_t req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial req = '0;

    // Idle write data is inverted so a stale value is never mistaken for fresh
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        req.addr = a;
        req.wr_data = d;
        req.wr_en = 1'b1;
        @(posedge clk_sys);
        #1;
        req.wr_en = 1'b0;
        req.wr_data = ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        req.addr = a;
        req.rd_en = 1'b1;
        @(posedge clk_sys);
        #1;
        req.rd_en = 1'b0;
        d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
    endtask
endmodule

// ===== dv/rtc_regs_properties.sv
// Port-level checks on the calendar and alarm register block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module rtc_regs_properties #(
    parameter int unsigned CYC_PER_SECOND = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input rtc_pkg::rtc_req_t req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    logic mode12_reg;
    logic [7:0] ra;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Mirror of the format bit, so the flag checks know the mode at read time
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode12_reg <= 1'b0;
        end
        else if (req.wr_en && req.addr == 8'h10)
        begin
            mode12_reg <= req.wr_data[3];
        end
    end

    assign ra = req.addr;

    second_resv_a: assert property (rd_valid && $past(ra) == 8'h00 |-> rd_data[7] == 1'b0)
        else $error("second reserved bit set");
    minute_resv_a: assert property (rd_valid && $past(ra) == 8'h01 |-> rd_data[7] == 1'b0)
        else $error("minute reserved bit set");
    hour_resv_a: assert property (rd_valid && $past(ra) == 8'h02 |-> rd_data[6] == 1'b0)
        else $error("hour reserved bit set");
    hour_flag_a: assert property (rd_valid && $past(ra) == 8'h02 && !$past(mode12_reg) |-> !rd_data[7])
        else $error("hour flag set in 24-hour mode");
    day_resv_a: assert property (rd_valid && $past(ra) == 8'h03 |-> rd_data[7:6] == 2'h0)
        else $error("day reserved bits set");
    month_resv_a: assert property (rd_valid && $past(ra) == 8'h04 |-> rd_data[7:5] == 3'h0)
        else $error("month reserved bits set");
    weekday_resv_a: assert property (rd_valid && $past(ra) == 8'h06 |-> rd_data[7:3] == 5'h00)
        else $error("weekday reserved bits set");
    alarm_resv_a: assert property (rd_valid && $past(ra) inside {8'h08, 8'h09} |-> !rd_data[7])
        else $error("alarm reserved bit set");
    alarm_hour_a: assert property (rd_valid && $past(ra) == 8'h0A |->
        !rd_data[6] && ($past(mode12_reg) || !rd_data[7]))
        else $error("alarm hour bits wrong");
endmodule

// ===== dv/tb_rtc_calendar_alarm_regs.sv
// Self-checking bench for the calendar and alarm register block.
// Assumes a shortened second of 40 clocks so rollover fits in a short run.
`timescale 1ns/100ps
module tb_rtc_calendar_alarm_regs;
    localparam int unsigned CYC = 40;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    rtc_pkg::rtc_req_t req;
    logic [7:0] rd_data;
    logic rd_valid;
    int err_total = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;
    logic [7:0] ofs [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h10};
    logic [7:0] rstv [11] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] fullv [10] = '{8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h1F, 8'hFF, 8'h07, 8'h7F, 8'h7F, 8'h3F};
    logic [7:0] roll [7] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99, 8'h06};

    always #20 clk_sys = ~clk_sys;

    rtc_calendar_alarm_regs #(.CYC_PER_SECOND(CYC)) i_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .req(req),
        .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    rtc_host_model i_host (
        .clk_sys(clk_sys),
        .req(req),
        .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd_reg(a, d);
        cmp_count++;
        if (d !== e)
        begin
            $display("[FAIL] t=%0t addr %h got %h exp %h", $time, a, d, e);
            err_total++;
        end
    endtask

    // Lets the clock run until the seconds field wraps, then freezes it again
    task automatic run_one_second;
        logic [7:0] d;
        i_host.wr_reg(8'h10, 8'h01);
        for (int n = 0; n < 100; n++)
        begin
            i_host.rd_reg(8'h00, d);
            if (d === 8'h00)
                break;
        end
        i_host.wr_reg(8'h10, 8'h00);
    endtask

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 11; i++)
            chk(ofs[i], rstv[i]);
        for (int i = 0; i < 10; i++)
        begin
            i_host.wr_reg(ofs[i], 8'hFF);
            chk(ofs[i], fullv[i]);
        end
        i_host.wr_reg(8'h07, 8'hFF);
        chk(8'h07, 8'h00);
        i_host.wr_reg(8'h10, 8'h08);
        chk(8'h10, 8'h08);
        i_host.wr_reg(8'h02, 8'h81);
        chk(8'h02, 8'h81);
        i_host.wr_reg(8'h0A, 8'h92);
        chk(8'h0A, 8'h92);
        i_host.wr_reg(8'h10, 8'h00);
        chk(8'h02, 8'h13);
        chk(8'h0A, 8'h12);
        // Last second of the century: every field must carry at once
        for (int i = 0; i < 7; i++)
            i_host.wr_reg(ofs[i], roll[i]);
        run_one_second();
        for (int i = 0; i < 7; i++)
            chk(ofs[i], rstv[i]);
        repeat (100) @(posedge clk_sys);
        chk(8'h00, 8'h00);
        i_host.wr_reg(8'h10, 8'h08);
        chk(8'h02, 8'h12);
        i_host.wr_reg(8'h02, 8'h92);
        chk(8'h02, 8'h92);
        i_host.wr_reg(8'h10, 8'h00);
        chk(8'h02, 8'h12);
        // End of February in a plain year, then in a leap year
        for (int k = 0; k < 2; k++)
        begin
            for (int i = 0; i < 3; i++)
                i_host.wr_reg(ofs[i], roll[i]);
            i_host.wr_reg(8'h03, 8'h28);
            i_host.wr_reg(8'h04, 8'h02);
            i_host.wr_reg(8'h05, (k == 1) ? 8'h04 : 8'h01);
            run_one_second();
            chk(8'h03, (k == 1) ? 8'h29 : 8'h01);
            chk(8'h04, (k == 1) ? 8'h02 : 8'h03);
            chk(8'h06, (k == 1) ? 8'h02 : 8'h01);
        end
        print_verdict();
    end
endmodule

bind rtc_calendar_alarm_regs rtc_regs_properties #(.CYC_PER_SECOND(CYC_PER_SECOND)) i_props (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(req),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
);

// ===== hdl/rtc_calendar_alarm_regs.sv
// Calendar, time and alarm registers with BCD timekeeping.
// Assumes the serial decoder presents single-cycle read and write strobes.
`timescale 1ns/100ps
module rtc_calendar_alarm_regs #(
    parameter int unsigned CYC_PER_SECOND = 32'(rtc_pkg::CYC_PER_SECOND)
) (
    input wire logic clk_sys,
    input wire logic rst,
    input rtc_pkg::rtc_req_t req,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    rtc_pkg::rtc_time_t time_reg;
    rtc_pkg::rtc_time_t time_next;
    rtc_pkg::rtc_alarm_t alarm_reg;
    logic [7:0] ctrl_reg;
    logic sec_tick;
    logic mode12;

    // Format bit is read live, so a mode switch never touches the stored count
    assign mode12 = ctrl_reg[rtc_pkg::CTRL_MODE12_BIT];

    // BCD step with wrap; bit 8 flags the wrap as a carry
    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                            input logic [7:0] hi);
        logic [8:0] r;
        r = 9'h000;
        if (v >= hi)
        begin
            r = {1'b1, lo};
        end
        else if (v[3:0] >= 4'h9)
        begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // Five bits cover every legal hour; out-of-range digits wrap silently
    function automatic logic [4:0] bcd_to_bin(input logic [7:0] v);
        logic [7:0] b;
        b = 8'((v[7:4] * 4'hA) + v[3:0]);
        return b[4:0];
    endfunction

    function automatic logic [7:0] bin_to_bcd(input logic [4:0] b);
        logic [4:0] t;
        t = 5'(b / 5'h0A);
        return {t[3:0], 4'(b - 5'(t * 5'h0A))};
    endfunction

    // Last day of the month in BCD; leap years are those divisible by four
    function automatic logic [7:0] month_last_day(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = (!y[4] && (y[1:0] == 2'h0)) || (y[4] && (y[1:0] == 2'h2));
        case (m)
            8'h02: month_last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last_day = 8'h30;
            default: month_last_day = 8'h31;
        endcase
    endfunction

    // Internal hour is always 24-hour BCD; 12-hour view made on read
    function automatic logic [7:0] hour_to_view(input logic [7:0] h24, input logic m12);
        logic [4:0] b;
        logic [4:0] h;
        logic [7:0] v;
        b = bcd_to_bin(h24);
        h = b;
        if (b >= 5'h0C)
        begin
            h = 5'(b - 5'h0C);
        end
        // Hours zero and twelve both show as 12 in the 12-hour view
        if (h == 5'h00)
        begin
            h = 5'h0C;
        end
        v = bin_to_bcd(h);
        if (m12)
        begin
            return {(b >= 5'h0C), 1'b0, v[5:0]};
        end
        return h24 & rtc_pkg::MASK_HOUR;
    endfunction

    function automatic logic [7:0] hour_from_view(input logic [7:0] v, input logic m12);
        logic [4:0] b;
        b = bcd_to_bin({2'b00, v[5:0]});
        if (!m12)
        begin
            return v & rtc_pkg::MASK_HOUR;
        end
        // 12 AM is hour zero, 12 PM stays twelve
        if (b == 5'h0C)
        begin
            b = 5'h00;
        end
        if (v[rtc_pkg::AFTERNOON_BIT])
        begin
            b = 5'(b + 5'h0C);
        end
        return bin_to_bcd(b);
    endfunction

    function automatic logic wr_hit(input rtc_pkg::rtc_req_t r, input logic [7:0] ofs);
        return r.wr_en && (r.addr == ofs);
    endfunction

    // Run bit gates the prescaler, so a restart always waits a full second
    rtc_sec_tick #(
        .CYC_PER_SECOND(CYC_PER_SECOND)
    ) u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(ctrl_reg[rtc_pkg::CTRL_RUN_BIT]),
        .tick(sec_tick)
    );

    // Carry chain, then software writes override the fields they hit
    always_comb
    begin
        logic [8:0] s;
        logic [8:0] mi;
        logic [8:0] h;
        logic [8:0] d;
        logic [8:0] mo;
        logic [8:0] y;
        logic [8:0] w;
        time_next = time_reg;
        s = bcd_step(time_reg.second, rtc_pkg::MIN_ZERO, rtc_pkg::MAX_SIXTY);
        mi = bcd_step(time_reg.minute, rtc_pkg::MIN_ZERO, rtc_pkg::MAX_SIXTY);
        h = bcd_step(time_reg.hour, rtc_pkg::MIN_ZERO, rtc_pkg::MAX_HOUR24);
        d = bcd_step(time_reg.day, rtc_pkg::MIN_ONE, month_last_day(time_reg.month, time_reg.year));
        mo = bcd_step(time_reg.month, rtc_pkg::MIN_ONE, rtc_pkg::MAX_MONTH);
        y = bcd_step(time_reg.year, rtc_pkg::MIN_ZERO, rtc_pkg::MAX_YEAR);
        w = bcd_step(time_reg.weekday, rtc_pkg::MIN_ZERO, rtc_pkg::MAX_WEEKDAY);
        if (sec_tick)
        begin
            time_next.second = s[7:0];
            if (s[8])
            begin
                time_next.minute = mi[7:0];
                if (mi[8])
                begin
                    time_next.hour = h[7:0];
                    if (h[8])
                    begin
                        time_next.day = d[7:0];
                        time_next.weekday = w[7:0];
                        if (d[8])
                        begin
                            time_next.month = mo[7:0];
                            if (mo[8])
                            begin
                                time_next.year = y[7:0];
                            end
                        end
                    end
                end
            end
        end
        // Writes are not range-clamped; an out-of-range digit wraps at the next carry
        if (wr_hit(req, rtc_pkg::OFS_SECOND))
        begin
            time_next.second = req.wr_data & rtc_pkg::MASK_SECOND;
        end
        if (wr_hit(req, rtc_pkg::OFS_MINUTE))
        begin
            time_next.minute = req.wr_data & rtc_pkg::MASK_MINUTE;
        end
        if (wr_hit(req, rtc_pkg::OFS_HOUR))
        begin
            time_next.hour = hour_from_view(req.wr_data, mode12);
        end
        if (wr_hit(req, rtc_pkg::OFS_DAY))
        begin
            time_next.day = req.wr_data & rtc_pkg::MASK_DAY;
        end
        if (wr_hit(req, rtc_pkg::OFS_MONTH))
        begin
            time_next.month = req.wr_data & rtc_pkg::MASK_MONTH;
        end
        if (wr_hit(req, rtc_pkg::OFS_YEAR))
        begin
            time_next.year = req.wr_data & rtc_pkg::MASK_YEAR;
        end
        if (wr_hit(req, rtc_pkg::OFS_WEEKDAY))
        begin
            time_next.weekday = req.wr_data & rtc_pkg::MASK_WEEKDAY;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            time_reg.second <= rtc_pkg::RST_SECOND;
            time_reg.minute <= rtc_pkg::RST_MINUTE;
            time_reg.hour <= rtc_pkg::RST_HOUR;
            time_reg.day <= rtc_pkg::RST_DAY;
            time_reg.month <= rtc_pkg::RST_MONTH;
            time_reg.year <= rtc_pkg::RST_YEAR;
            time_reg.weekday <= rtc_pkg::RST_WEEKDAY;
        end
        else
        begin
            time_reg <= time_next;
        end
    end

    // Alarm registers keep the format they were written in
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            alarm_reg <= {3{rtc_pkg::RST_ALARM}};
        end
        else
        begin
            if (wr_hit(req, rtc_pkg::OFS_ALM_SECOND))
            begin
                alarm_reg.second <= req.wr_data & rtc_pkg::MASK_SECOND;
            end
            if (wr_hit(req, rtc_pkg::OFS_ALM_MINUTE))
            begin
                alarm_reg.minute <= req.wr_data & rtc_pkg::MASK_MINUTE;
            end
            // Flag dropped in 24-hour mode so a later switch cannot show a stale PM
            if (wr_hit(req, rtc_pkg::OFS_ALM_HOUR))
            begin
                alarm_reg.hour <= {req.wr_data[rtc_pkg::AFTERNOON_BIT] & mode12,
                                   req.wr_data[6:0] & rtc_pkg::MASK_HOUR[6:0]};
            end
        end
    end

    // Only run and format bits are kept; the other control bits read zero
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_reg <= rtc_pkg::RST_CTRL;
        end
        else if (wr_hit(req, rtc_pkg::OFS_CTRL))
        begin
            ctrl_reg <= req.wr_data & rtc_pkg::MASK_CTRL;
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= req.rd_en;
            if (req.rd_en)
            begin
                case (req.addr)
                    rtc_pkg::OFS_SECOND: rd_data <= time_reg.second;
                    rtc_pkg::OFS_MINUTE: rd_data <= time_reg.minute;
                    rtc_pkg::OFS_HOUR: rd_data <= hour_to_view(time_reg.hour, mode12);
                    rtc_pkg::OFS_DAY: rd_data <= time_reg.day;
                    rtc_pkg::OFS_MONTH: rd_data <= time_reg.month;
                    rtc_pkg::OFS_YEAR: rd_data <= time_reg.year;
                    rtc_pkg::OFS_WEEKDAY: rd_data <= time_reg.weekday;
                    rtc_pkg::OFS_ALM_SECOND: rd_data <= alarm_reg.second;
                    rtc_pkg::OFS_ALM_MINUTE: rd_data <= alarm_reg.minute;
                    rtc_pkg::OFS_ALM_HOUR: rd_data <= {alarm_reg.hour[7] & mode12, alarm_reg.hour[6:0]};
                    rtc_pkg::OFS_CTRL: rd_data <= ctrl_reg;
                    default: rd_data <= 8'h00;
                endcase
            end
        end
    end
endmodule

// ===== hdl/rtc_sec_tick.sv
// One-second tick generator for the calendar counters.
// Assumes clk_sys runs at the rate the package names.
`timescale 1ns/100ps
module rtc_sec_tick #(
    parameter int unsigned CYC_PER_SECOND = 32'(rtc_pkg::CYC_PER_SECOND)
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    output logic tick
);
    logic [31:0] count_reg;

    // Prescaler clears while frozen so restart gives a full second
    always_ff @(posedge clk_sys)
    begin
        if (rst || !run)
        begin
            count_reg <= 32'h0000_0000;
        end
        else if (count_reg == CYC_PER_SECOND - 1)
        begin
            count_reg <= 32'h0000_0000;
        end
        else
        begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tick <= 1'b0;
        end
        else
        begin
            tick <= run && (count_reg == CYC_PER_SECOND - 1);
        end
    end
endmodule
